// file: serial_params.svh
// Constants for the asynchronous serial transceiver
// Summary of operation
// - Parity error rises on mismatched parity, stays until a matching character arrives
// - Framing error rises on a bad first stop bit, stays until a good one
// - Overrun rises when a character lands while receive-ready is still set
// - Overrun clears at the next stop bit if receive-ready clear was driven low
// - Status-disable high drives STATUS_OE low; the status outputs themselves stay driven
// - Receive and transmit run from outside clocks at sixteen times the bit rate
// - Receive-ready is forced low while its clear input is held low
// - Receive-ready rises once a character sits in the receive buffer
// - Master clear zeroes error flags, ready, shift-empty; sets holding-empty and line
// - Shift-empty returns within 18 clocks after master clear; buffer is kept
// - Holding-empty rises once the holding register passed its character on
// - Transmit inputs are captured into the holding register while load is low
// - Load rising edge requests transfer, deferred while the shifter is busy
// - Shift-empty rises after the stop bits have been sent, and when idle after master clear
// - Start, data, parity and stop bits go out in sequence
// - Unused upper transmit inputs are ignored for short words
// - Configuration latch high loads parity-off, stop, length and even selects
// - Parity-off disables generation and checking and holds parity error low
// - Extra stop gives 1.5 stops for 5-bit words, 2 otherwise
// - Length selects give 5, 6, 7 or 8 bits
// - Even-parity select high gives even parity, low gives odd
// - Start bit centre is taken at count 7-1/2 of the 16x clock
// - Short received words are right-justified with upper bits low
// - Buffer loads in the first stop bit; ready and framing follow one clock later
// - Search for the next start bit resumes at the first stop bit centre
`ifndef SERIAL_PARAMS_SVH
`define SERIAL_PARAMS_SVH
`define REF_CLK_PERIOD_NS 50
`define OVERSAMPLE 16
`define TICK_LAST 4'hF
`define START_CENTRE 4'h7
`define STOP_TICKS_ONE 5'h0F
`define STOP_TICKS_ONE_HALF 5'h17
`define STOP_TICKS_TWO 5'h1F
`define SYNC_STAGES 2
`define CFG_RESET 5'h00
`define LINE_IDLE 1'b1
`endif

// file: serial_pkg.sv
// Types shared by the transceiver modules
package serial_pkg;
   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_START = 3'h1,
      ST_DATA = 3'h3,
      ST_PARITY = 3'h2,
      ST_STOP = 3'h6
   } frame_state_e;
   typedef struct packed {
      logic parity_off;
      logic extra_stop;
      logic word_len_sel_hi;
      logic word_len_sel_lo;
      logic even_parity_sel;
   } cfg_s;
   typedef logic [7:0] char_t;
endpackage

// file: tx_link_if.sv
// Signals between the top and its transmit engine
interface tx_link_if;
   serial_pkg::cfg_s cfg;
   logic master_clear;
   logic tick;
   logic load_low;
   logic load_rise;
   serial_pkg::char_t tx_parallel_in;
   logic tx_holding_empty;
   logic tx_shift_empty;
   logic tx_serial_out;
   modport top (output cfg, master_clear, tick, load_low, load_rise, tx_parallel_in,
      input tx_holding_empty, tx_shift_empty, tx_serial_out);
   modport engine (input cfg, master_clear, tick, load_low, load_rise, tx_parallel_in,
      output tx_holding_empty, tx_shift_empty, tx_serial_out);
endinterface

// file: pin_sync.sv
// Two-stage synchroniser for a group of pins
`include "serial_params.svh"
module pin_sync #(
   parameter int WIDTH = 8
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   // ==========================================
   // Per-bit stages
   genvar i;
   generate
      for (i = 0; i < WIDTH; i++) begin : g_bit
         logic [`SYNC_STAGES-1:0] stage_reg;
         always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               stage_reg <= '0;
            end else begin
               stage_reg <= {stage_reg[`SYNC_STAGES-2:0], async_in[i]};
            end
         end
         assign sync_out[i] = stage_reg[`SYNC_STAGES-1];
      end
   endgenerate
endmodule // pin_sync

// file: serial_tx.sv
// Transmit holding register and shift engine
`include "serial_params.svh"
module serial_tx (
   input wire logic clk,
   input wire logic rst_n,
   tx_link_if.engine lnk
);
   serial_pkg::frame_state_e state_reg;
   serial_pkg::char_t hold_reg;
   serial_pkg::char_t shift_reg;
   logic pend_reg;
   logic par_reg;
   logic [3:0] tick_reg;
   logic [2:0] bits_reg;
   logic [4:0] stop_reg;
   logic hold_empty_reg;
   logic shift_empty_reg;
   logic serial_reg;

   // ==========================================
   // Format decode
   wire logic [2:0] last_bit = {1'b1, lnk.cfg.word_len_sel_hi, lnk.cfg.word_len_sel_lo};
   wire logic five_bit = ~lnk.cfg.word_len_sel_hi & ~lnk.cfg.word_len_sel_lo;
   wire logic [4:0] stop_last = !lnk.cfg.extra_stop ? `STOP_TICKS_ONE :
      (five_bit ? `STOP_TICKS_ONE_HALF : `STOP_TICKS_TWO);
   wire serial_pkg::char_t len_mask = serial_pkg::char_t'(8'hFF >> (3'h7 - last_bit));
   wire serial_pkg::char_t masked = hold_reg & len_mask;
   wire logic parity_bit = (^masked) ^ ~lnk.cfg.even_parity_sel;
   wire logic bit_end = lnk.tick && (tick_reg == `TICK_LAST);
   // Transfer waits for the shifter so characters go out end to end
   wire logic transfer = pend_reg && (state_reg == serial_pkg::ST_IDLE) && !lnk.master_clear;

   assign lnk.tx_holding_empty = hold_empty_reg;
   assign lnk.tx_shift_empty = shift_empty_reg;
   assign lnk.tx_serial_out = serial_reg;

   // ==========================================
   // Holding register
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         hold_reg <= '0;
         pend_reg <= 1'b0;
         hold_empty_reg <= 1'b1;
      end else begin
         if (lnk.load_low) begin
            hold_reg <= lnk.tx_parallel_in;
         end
         if (lnk.master_clear) begin
            pend_reg <= 1'b0;
            hold_empty_reg <= 1'b1;
         end else if (lnk.load_rise) begin
            pend_reg <= 1'b1;
            hold_empty_reg <= 1'b0;
         end else if (transfer) begin
            pend_reg <= 1'b0;
            hold_empty_reg <= 1'b1;
         end
      end
   end

   // ==========================================
   // Shift engine
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= serial_pkg::ST_IDLE;
         shift_reg <= '0;
         par_reg <= 1'b0;
         tick_reg <= '0;
         bits_reg <= '0;
         stop_reg <= '0;
         shift_empty_reg <= 1'b0;
         serial_reg <= `LINE_IDLE;
      end else if (lnk.master_clear) begin
         state_reg <= serial_pkg::ST_IDLE;
         shift_empty_reg <= 1'b0;
         serial_reg <= `LINE_IDLE;
      end else if (transfer) begin
         state_reg <= serial_pkg::ST_START;
         shift_reg <= masked;
         par_reg <= parity_bit;
         tick_reg <= '0;
         bits_reg <= '0;
         shift_empty_reg <= 1'b0;
         serial_reg <= 1'b0;
      end else if (state_reg == serial_pkg::ST_IDLE) begin
         shift_empty_reg <= 1'b1;
      end else begin
         if (lnk.tick) begin
            tick_reg <= tick_reg + 4'h1;
         end
         unique case (state_reg)
            serial_pkg::ST_START: if (bit_end) begin
               state_reg <= serial_pkg::ST_DATA;
               serial_reg <= shift_reg[0];
            end
            serial_pkg::ST_DATA: if (bit_end) begin
               shift_reg <= {1'b0, shift_reg[7:1]};
               bits_reg <= bits_reg + 3'h1;
               if (bits_reg == last_bit) begin
                  state_reg <= lnk.cfg.parity_off ? serial_pkg::ST_STOP : serial_pkg::ST_PARITY;
                  serial_reg <= lnk.cfg.parity_off ? 1'b1 : par_reg;
                  stop_reg <= '0;
               end else begin
                  serial_reg <= shift_reg[1];
               end
            end
            serial_pkg::ST_PARITY: if (bit_end) begin
               state_reg <= serial_pkg::ST_STOP;
               serial_reg <= 1'b1;
               stop_reg <= '0;
            end
            serial_pkg::ST_STOP: if (lnk.tick) begin
               stop_reg <= stop_reg + 5'h01;
               if (stop_reg == stop_last) begin
                  state_reg <= serial_pkg::ST_IDLE;
                  shift_empty_reg <= 1'b1;
               end
            end
            default: state_reg <= serial_pkg::ST_IDLE;
         endcase
      end
   end
endmodule // serial_tx

// file: serial_transceiver.sv
// Asynchronous serial transceiver top: pins, configuration, receiver, status
`include "serial_params.svh"
module serial_transceiver #(
   parameter int DATA_W = 8
) (
   input wire logic REF_CLK,
   input wire logic RSTN,
   input wire logic RX_BIT_CLOCK,
   input wire logic TX_BIT_CLOCK,
   input wire logic RX_SERIAL_IN,
   input wire logic MASTER_CLEAR,
   input wire logic CONFIG_LATCH,
   input wire logic PARITY_OFF,
   input wire logic EXTRA_STOP_SELECT,
   input wire logic WORD_LEN_SEL_LO,
   input wire logic WORD_LEN_SEL_HI,
   input wire logic EVEN_PARITY_SEL,
   input wire logic TX_HOLDING_LOAD_N,
   input wire logic [DATA_W-1:0] TX_PARALLEL_IN,
   input wire logic RX_READY_CLEAR_N,
   input wire logic STATUS_OUTPUTS_FLOAT,
   output logic [DATA_W-1:0] RX_PARALLEL_OUT,
   output logic TX_SERIAL_OUT,
   output logic PARITY_ERROR_FLAG,
   output logic FRAMING_ERROR_FLAG,
   output logic OVERRUN_ERROR_FLAG,
   output logic RX_READY,
   output logic TX_HOLDING_EMPTY,
   output logic TX_SHIFT_EMPTY,
   output logic STATUS_OE
);
   localparam int PIN_W = 13 + DATA_W;

   // ==========================================
   // Elaboration check
   generate
      if (DATA_W != 8) begin : g_bad_width
         $error("serial_transceiver supports only an 8-bit character path");
      end
   endgenerate

   tx_link_if tx_lnk ();

   logic [PIN_W-1:0] pin_async;
   logic [PIN_W-1:0] pin_sync_q;
   logic rx_clk_s;
   logic tx_clk_s;
   logic rx_in_s;
   logic mclr_s;
   logic cfg_latch_s;
   logic load_n_s;
   logic ready_clr_n_s;
   logic float_s;
   serial_pkg::cfg_s cfg_pins_s;
   serial_pkg::char_t tx_data_s;

   serial_pkg::cfg_s cfg_reg;
   logic rx_clk_d_reg;
   logic tx_clk_d_reg;
   logic load_n_d_reg;
   serial_pkg::frame_state_e rx_state_reg;
   logic [3:0] rx_tick_reg;
   logic [2:0] rx_bits_reg;
   serial_pkg::char_t rx_shift_reg;
   logic rx_par_reg;
   logic stop_bit_reg;
   logic settle_reg;
   logic cleared_seen_reg;
   serial_pkg::char_t rx_buf_reg;
   logic perr_reg;
   logic ferr_reg;
   logic oerr_reg;
   logic ready_reg;
   logic tx_serial_reg;
   logic tx_hold_empty_reg;
   logic tx_shift_empty_reg;
   logic status_oe_reg;

   // ==========================================
   // Pin synchronisation
   // Bit clocks arrive as pins, so they are sampled; they must stay below a quarter of REF_CLK
   // Idle-high pins enter inverted so a synchroniser in reset reads idle
   assign pin_async = {RX_BIT_CLOCK, TX_BIT_CLOCK, ~RX_SERIAL_IN, MASTER_CLEAR, CONFIG_LATCH,
      PARITY_OFF, EXTRA_STOP_SELECT, WORD_LEN_SEL_HI, WORD_LEN_SEL_LO, EVEN_PARITY_SEL,
      ~TX_HOLDING_LOAD_N, ~RX_READY_CLEAR_N, STATUS_OUTPUTS_FLOAT, TX_PARALLEL_IN};

   pin_sync #(
      .WIDTH(PIN_W)
   ) u_pin_sync (
      .clk(REF_CLK),
      .rst_n(RSTN),
      .async_in(pin_async),
      .sync_out(pin_sync_q)
   );

   assign rx_clk_s = pin_sync_q[PIN_W-1];
   assign tx_clk_s = pin_sync_q[PIN_W-2];
   assign rx_in_s = ~pin_sync_q[PIN_W-3];
   assign mclr_s = pin_sync_q[PIN_W-4];
   assign cfg_latch_s = pin_sync_q[PIN_W-5];
   assign cfg_pins_s = serial_pkg::cfg_s'(pin_sync_q[PIN_W-6:PIN_W-10]);
   assign load_n_s = ~pin_sync_q[PIN_W-11];
   assign ready_clr_n_s = ~pin_sync_q[PIN_W-12];
   assign float_s = pin_sync_q[PIN_W-13];
   assign tx_data_s = pin_sync_q[DATA_W-1:0];

   // ==========================================
   // Edge detection and configuration
   wire logic rx_tick = rx_clk_s & ~rx_clk_d_reg;
   wire logic tx_tick = tx_clk_s & ~tx_clk_d_reg;
   wire logic load_rise = load_n_s & ~load_n_d_reg;

   always_ff @(posedge REF_CLK or negedge RSTN) begin
      if (!RSTN) begin
         rx_clk_d_reg <= 1'b0;
         tx_clk_d_reg <= 1'b0;
         load_n_d_reg <= 1'b1;
         cfg_reg <= serial_pkg::cfg_s'(`CFG_RESET);
      end else begin
         rx_clk_d_reg <= rx_clk_s;
         tx_clk_d_reg <= tx_clk_s;
         load_n_d_reg <= load_n_s;
         if (cfg_latch_s) begin
            cfg_reg <= cfg_pins_s;
         end
      end
   end

   // ==========================================
   // Transmit engine
   assign tx_lnk.cfg = cfg_reg;
   assign tx_lnk.master_clear = mclr_s;
   assign tx_lnk.tick = tx_tick;
   assign tx_lnk.load_low = ~load_n_s;
   assign tx_lnk.load_rise = load_rise;
   assign tx_lnk.tx_parallel_in = tx_data_s;

   serial_tx u_serial_tx (
      .clk(REF_CLK),
      .rst_n(RSTN),
      .lnk(tx_lnk.engine)
   );

   // ==========================================
   // Receiver decode
   wire logic [2:0] rx_last_bit = {1'b1, cfg_reg.word_len_sel_hi, cfg_reg.word_len_sel_lo};
   wire logic rx_bit_end = rx_tick && (rx_tick_reg == `TICK_LAST);
   wire logic rx_centre = rx_tick && (rx_tick_reg == `START_CENTRE);
   // Data shifts in from the top, so a short word is sitting high and is moved down
   wire serial_pkg::char_t rx_justified =
      serial_pkg::char_t'(rx_shift_reg >> (3'h7 - rx_last_bit));
   wire logic rx_expected_par = (^rx_justified) ^ ~cfg_reg.even_parity_sel;
   wire logic rx_par_bad = ~cfg_reg.parity_off && (rx_par_reg != rx_expected_par);
   wire logic rx_load = (rx_state_reg == serial_pkg::ST_STOP) && rx_bit_end && !mclr_s;

   // ==========================================
   // Receiver state machine
   always_ff @(posedge REF_CLK or negedge RSTN) begin
      if (!RSTN) begin
         rx_state_reg <= serial_pkg::ST_IDLE;
         rx_tick_reg <= '0;
         rx_bits_reg <= '0;
         rx_shift_reg <= '0;
         rx_par_reg <= 1'b0;
         stop_bit_reg <= 1'b1;
      end else if (mclr_s) begin
         rx_state_reg <= serial_pkg::ST_IDLE;
      end else if (rx_tick) begin
         rx_tick_reg <= rx_tick_reg + 4'h1;
         unique case (rx_state_reg)
            serial_pkg::ST_IDLE: if (!rx_in_s) begin
               rx_state_reg <= serial_pkg::ST_START;
               rx_tick_reg <= '0;
            end
            serial_pkg::ST_START: if (rx_centre) begin
               // A start bit that is high again at its centre was a glitch
               rx_state_reg <= rx_in_s ? serial_pkg::ST_IDLE : serial_pkg::ST_DATA;
               rx_tick_reg <= '0;
               rx_bits_reg <= '0;
            end
            serial_pkg::ST_DATA: if (rx_bit_end) begin
               rx_shift_reg <= {rx_in_s, rx_shift_reg[7:1]};
               rx_bits_reg <= rx_bits_reg + 3'h1;
               if (rx_bits_reg == rx_last_bit) begin
                  rx_state_reg <= cfg_reg.parity_off ? serial_pkg::ST_STOP :
                     serial_pkg::ST_PARITY;
               end
            end
            serial_pkg::ST_PARITY: if (rx_bit_end) begin
               rx_par_reg <= rx_in_s;
               rx_state_reg <= serial_pkg::ST_STOP;
            end
            serial_pkg::ST_STOP: if (rx_bit_end) begin
               stop_bit_reg <= rx_in_s;
               rx_state_reg <= serial_pkg::ST_IDLE;
            end
            default: rx_state_reg <= serial_pkg::ST_IDLE;
         endcase
      end
   end

   // ==========================================
   // Receive buffer and status flags
   always_ff @(posedge REF_CLK or negedge RSTN) begin
      if (!RSTN) begin
         rx_buf_reg <= '0;
         settle_reg <= 1'b0;
         cleared_seen_reg <= 1'b0;
         perr_reg <= 1'b0;
         ferr_reg <= 1'b0;
         oerr_reg <= 1'b0;
         ready_reg <= 1'b0;
      end else if (mclr_s) begin
         // Buffer contents survive master clear
         settle_reg <= 1'b0;
         cleared_seen_reg <= 1'b0;
         perr_reg <= 1'b0;
         ferr_reg <= 1'b0;
         oerr_reg <= 1'b0;
         ready_reg <= 1'b0;
      end else begin
         settle_reg <= rx_load;
         if (rx_load) begin
            rx_buf_reg <= rx_justified;
            perr_reg <= rx_par_bad;
            cleared_seen_reg <= 1'b0;
            if (ready_reg) begin
               oerr_reg <= 1'b1;
            end else if (cleared_seen_reg || !ready_clr_n_s) begin
               oerr_reg <= 1'b0;
            end
         end else if (!ready_clr_n_s) begin
            cleared_seen_reg <= 1'b1;
         end
         if (cfg_reg.parity_off) begin
            perr_reg <= 1'b0;
         end
         if (settle_reg) begin
            ferr_reg <= ~stop_bit_reg;
         end
         // The clear level wins over a new character while it is held low
         if (!ready_clr_n_s) begin
            ready_reg <= 1'b0;
         end else if (settle_reg) begin
            ready_reg <= 1'b1;
         end
      end
   end

   // ==========================================
   // Output registers
   always_ff @(posedge REF_CLK or negedge RSTN) begin
      if (!RSTN) begin
         tx_serial_reg <= `LINE_IDLE;
         tx_hold_empty_reg <= 1'b1;
         tx_shift_empty_reg <= 1'b0;
         status_oe_reg <= 1'b0;
      end else begin
         tx_serial_reg <= tx_lnk.tx_serial_out;
         tx_hold_empty_reg <= tx_lnk.tx_holding_empty;
         tx_shift_empty_reg <= tx_lnk.tx_shift_empty;
         status_oe_reg <= ~float_s;
      end
   end

   assign RX_PARALLEL_OUT = rx_buf_reg;
   assign TX_SERIAL_OUT = tx_serial_reg;
   assign PARITY_ERROR_FLAG = perr_reg;
   assign FRAMING_ERROR_FLAG = ferr_reg;
   assign OVERRUN_ERROR_FLAG = oerr_reg;
   assign RX_READY = ready_reg;
   assign TX_HOLDING_EMPTY = tx_hold_empty_reg;
   assign TX_SHIFT_EMPTY = tx_shift_empty_reg;
   assign STATUS_OE = status_oe_reg;
endmodule // serial_transceiver

// file: serial_transceiver_assertions.sv
// Port-level checks for the serial transceiver top
module serial_transceiver_assertions #(
   parameter int DATA_W = 8
) (
   input wire logic REF_CLK,
   input wire logic RSTN,
   input wire logic MASTER_CLEAR,
   input wire logic CONFIG_LATCH,
   input wire logic PARITY_OFF,
   input wire logic TX_HOLDING_LOAD_N,
   input wire logic RX_READY_CLEAR_N,
   input wire logic STATUS_OUTPUTS_FLOAT,
   input wire logic [DATA_W-1:0] RX_PARALLEL_OUT,
   input wire logic TX_SERIAL_OUT,
   input wire logic PARITY_ERROR_FLAG,
   input wire logic FRAMING_ERROR_FLAG,
   input wire logic OVERRUN_ERROR_FLAG,
   input wire logic RX_READY,
   input wire logic TX_HOLDING_EMPTY,
   input wire logic TX_SHIFT_EMPTY,
   input wire logic STATUS_OE
);
   // ==========================
   // Level inputs pass two sync flops and at most two more registers, so six cycles is ample
   default clocking cb @(posedge REF_CLK);
   endclocking
   default disable iff (!RSTN);
   chk_mc_clears_all:
   assert property (MASTER_CLEAR [*6] |-> !PARITY_ERROR_FLAG && !FRAMING_ERROR_FLAG &&
      !OVERRUN_ERROR_FLAG && !RX_READY && !TX_SHIFT_EMPTY && TX_HOLDING_EMPTY && TX_SERIAL_OUT)
      else $error("master clear left a status output wrong");
   chk_shift_returns:
   assert property ($fell(MASTER_CLEAR) |-> ##[1:17] TX_SHIFT_EMPTY)
      else $error("shift empty late after master clear");
   chk_float_status:
   assert property (STATUS_OUTPUTS_FLOAT [*6] |-> !STATUS_OE)
      else $error("status outputs still driven");
   chk_drive_status:
   assert property (!STATUS_OUTPUTS_FLOAT [*6] |-> STATUS_OE)
      else $error("status outputs not driven");
   chk_clear_ready:
   assert property (!RX_READY_CLEAR_N [*6] |-> !RX_READY)
      else $error("ready high while clear held");
   chk_parity_off:
   assert property ((CONFIG_LATCH && PARITY_OFF) [*6] |-> !PARITY_ERROR_FLAG)
      else $error("parity error with parity off");
   chk_load_taken:
   assert property ($rose(TX_HOLDING_LOAD_N) |-> ##[1:6] !TX_HOLDING_EMPTY)
      else $error("load edge not taken");
   chk_idle_high:
   assert property (TX_SHIFT_EMPTY |-> TX_SERIAL_OUT)
      else $error("line low while shifter empty");
   chk_start_low:
   assert property ($fell(TX_SHIFT_EMPTY) && !MASTER_CLEAR |-> !TX_SERIAL_OUT && TX_HOLDING_EMPTY)
      else $error("frame did not open with start bit");
   chk_buffer_first:
   assert property ($rose(RX_READY) |-> $stable(RX_PARALLEL_OUT))
      else $error("buffer changed with ready");
endmodule // serial_transceiver_assertions

bind serial_transceiver serial_transceiver_assertions #(.DATA_W(DATA_W)) i_chk (
   .REF_CLK(REF_CLK), .RSTN(RSTN), .MASTER_CLEAR(MASTER_CLEAR), .CONFIG_LATCH(CONFIG_LATCH),
   .PARITY_OFF(PARITY_OFF), .TX_HOLDING_LOAD_N(TX_HOLDING_LOAD_N),
   .RX_READY_CLEAR_N(RX_READY_CLEAR_N), .STATUS_OUTPUTS_FLOAT(STATUS_OUTPUTS_FLOAT),
   .RX_PARALLEL_OUT(RX_PARALLEL_OUT), .TX_SERIAL_OUT(TX_SERIAL_OUT),
   .PARITY_ERROR_FLAG(PARITY_ERROR_FLAG), .FRAMING_ERROR_FLAG(FRAMING_ERROR_FLAG),
   .OVERRUN_ERROR_FLAG(OVERRUN_ERROR_FLAG), .RX_READY(RX_READY),
   .TX_HOLDING_EMPTY(TX_HOLDING_EMPTY), .TX_SHIFT_EMPTY(TX_SHIFT_EMPTY), .STATUS_OE(STATUS_OE)
);

// file: serial_peer.sv
// Remote serial peer: bit clocks, frame sender and frame sampler
module serial_peer (
   output logic rx_bit_clock,
   output logic tx_bit_clock,
   output logic rx_serial_in,
   input wire logic tx_serial_out
);
   timeunit 1ns;
   timeprecision 1ns;
   // ==========================
   // Bit clocks, 16 ticks a bit; unequal rates keep the directions out of step
   initial begin
      rx_bit_clock = 1'b0;
      tx_bit_clock = 1'b0;
      rx_serial_in = 1'b1;
   end
   always #200 rx_bit_clock = ~rx_bit_clock;
   always #205 tx_bit_clock = ~tx_bit_clock;
   // ==========================
   // Frame sender, bit 0 of v first
   task automatic send(input logic [15:0] v, input int n);
      for (int i = 0; i < n; i++) begin
         @(posedge rx_bit_clock);
         rx_serial_in = v[i];
         repeat (15) @(posedge rx_bit_clock);
      end
      @(posedge rx_bit_clock);
      rx_serial_in = 1'b1;
   endtask
   // ==========================
   // Frame sampler at bit centres; returns at the centre of the last bit
   task automatic recv(input int n, output logic [15:0] v, output bit ok);
      int t;
      v = '1;
      ok = 1'b0;
      for (t = 0; t < 2000 && tx_serial_out !== 1'b0; t++) @(posedge tx_bit_clock);
      if (tx_serial_out !== 1'b0) return;
      repeat (8) @(posedge tx_bit_clock);
      v[0] = tx_serial_out;
      for (int i = 1; i < n; i++) begin
         repeat (16) @(posedge tx_bit_clock);
         v[i] = tx_serial_out;
      end
      ok = 1'b1;
   endtask
endmodule // serial_peer

// file: tb.sv
// Self-checking bench for the serial transceiver
`define CHECK(got, exp) begin checks_done++; if ((got) !== (exp)) begin num_errors++; \
   $display("CHECK FAILED at %0t: got %0h expected %0h", $time, (got), (exp)); end end
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic ref_clk = 1'b0;
   logic rstn, mclr, latch, p_off, x_stop, wl_lo, wl_hi, ev_par, load_n, clr_n, flt;
   logic [7:0] tx_data;
   wire logic [7:0] rx_data;
   wire logic rx_clk, tx_clk, rx_line, tx_line, par_err, frm_err, ovr_err, rdy;
   wire logic h_empty, s_empty, s_oe;
   int num_errors = 0;
   int checks_done = 0;
   always #25 ref_clk = ~ref_clk;
   serial_transceiver #(.DATA_W(8)) i_dut (
      .REF_CLK(ref_clk), .RSTN(rstn), .RX_BIT_CLOCK(rx_clk), .TX_BIT_CLOCK(tx_clk),
      .RX_SERIAL_IN(rx_line), .MASTER_CLEAR(mclr), .CONFIG_LATCH(latch), .PARITY_OFF(p_off),
      .EXTRA_STOP_SELECT(x_stop), .WORD_LEN_SEL_LO(wl_lo), .WORD_LEN_SEL_HI(wl_hi),
      .EVEN_PARITY_SEL(ev_par), .TX_HOLDING_LOAD_N(load_n), .TX_PARALLEL_IN(tx_data),
      .RX_READY_CLEAR_N(clr_n), .STATUS_OUTPUTS_FLOAT(flt), .RX_PARALLEL_OUT(rx_data),
      .TX_SERIAL_OUT(tx_line), .PARITY_ERROR_FLAG(par_err), .FRAMING_ERROR_FLAG(frm_err),
      .OVERRUN_ERROR_FLAG(ovr_err), .RX_READY(rdy), .TX_HOLDING_EMPTY(h_empty),
      .TX_SHIFT_EMPTY(s_empty), .STATUS_OE(s_oe));
   serial_peer i_peer (.rx_bit_clock(rx_clk), .tx_bit_clock(tx_clk), .rx_serial_in(rx_line),
      .tx_serial_out(tx_line));
   // ==========================
   // Helpers
   task tick(input int n);
      repeat (n) @(posedge ref_clk);
      #5;
   endtask
   task test_done;
      $display("mismatches %0d, comparisons %0d", num_errors, checks_done);
      if (num_errors == 0 && checks_done > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // Frame image, LSB first, with bits past the end left high like an idle line
   function automatic int mkframe(input logic [7:0] d, input int len, input logic pon,
      input logic ev, input logic badp, input logic stb, input int nst, output logic [15:0] v);
      int n;
      logic p;
      v = '1;
      v[0] = 1'b0;
      n = 1;
      p = ~ev;
      for (int i = 0; i < len; i++) begin
         v[n] = d[i];
         p = p ^ d[i];
         n++;
      end
      if (pon) begin
         v[n] = p ^ badp;
         n++;
      end
      v[n] = stb;
      return n + nst;
   endfunction
   task cfg(input logic po, input logic xs, input logic hi, input logic lo, input logic ev);
      p_off = po;
      x_stop = xs;
      wl_hi = hi;
      wl_lo = lo;
      ev_par = ev;
      latch = 1'b1;
      tick(7);
      latch = 1'b0;
      tick(3);
   endtask
   task send_rx(input logic [7:0] d, input int len, input logic pon, input logic badp,
      input logic stb);
      logic [15:0] v;
      int n;
      n = mkframe(d, len, pon, ev_par, badp, stb, 1, v);
      i_peer.send(v, n);
      tick(4);
   endtask
   task clear_ready;
      clr_n = 1'b0;
      tick(6);
      `CHECK(rdy, 1'b0)
      clr_n = 1'b1;
      tick(2);
   endtask
   task load(input logic [7:0] d);
      tx_data = d;
      load_n = 1'b0;
      tick(4);
      load_n = 1'b1;
      tick(1);
   endtask
   // ==========================
   // Scenarios
   task mclear_check(input logic [7:0] keep);
      int i;
      mclr = 1'b1;
      tick(8);
      `CHECK({par_err, frm_err, ovr_err, rdy, s_empty, h_empty, tx_line}, 7'h03)
      `CHECK(rx_data, keep)
      mclr = 1'b0;
      for (i = 0; i < 17 && s_empty !== 1'b1; i++) tick(1);
      `CHECK(s_empty, 1'b1)
      tick(6);
      $display("master clear test done");
   endtask
   task test_rx_errors;
      cfg(1'b0, 1'b0, 1'b1, 1'b1, 1'b1);
      send_rx(8'hA5, 8, 1'b1, 1'b0, 1'b1);
      `CHECK({rx_data, rdy, par_err, frm_err, ovr_err}, {8'hA5, 4'h8})
      send_rx(8'h3C, 8, 1'b1, 1'b1, 1'b1);
      `CHECK({rx_data, par_err, ovr_err}, {8'h3C, 2'h3})
      $display("receive error test done");
   endtask
   task test_rx_lengths;
      for (int c = 0; c < 4; c++) begin
         clear_ready();
         cfg(1'b1, 1'b0, c[1], c[0], 1'b0);
         send_rx(8'hFF, 5 + c, 1'b0, 1'b0, 1'b1);
         `CHECK({rx_data, rdy, par_err, ovr_err}, {8'hFF >> (3 - c), 3'h4})
      end
      $display("receive length test done");
   endtask
   task test_rx_framing;
      clear_ready();
      cfg(1'b0, 1'b0, 1'b1, 1'b1, 1'b1);
      send_rx(8'h5A, 8, 1'b1, 1'b0, 1'b0);
      `CHECK({rx_data, rdy, par_err, frm_err}, {8'h5A, 3'h5})
      $display("framing test done");
      mclear_check(8'h5A);
   endtask
   task test_tx;
      logic [15:0] g1, g2, e1, e2;
      bit ok1, ok2;
      int n1, n2, i;
      cfg(1'b0, 1'b1, 1'b1, 1'b0, 1'b0);
      n1 = mkframe(8'hFF, 7, 1'b1, 1'b0, 1'b0, 1'b1, 2, e1);
      n2 = mkframe(8'h83, 7, 1'b1, 1'b0, 1'b0, 1'b1, 2, e2);
      fork
         begin
            i_peer.recv(n1, g1, ok1);
            i_peer.recv(n2, g2, ok2);
         end
         begin
            load(8'hFF);
            for (i = 0; i < 20 && s_empty !== 1'b0; i++) tick(1);
            `CHECK({h_empty, s_empty}, 2'h2)
            load(8'h83);
            tick(6);
            `CHECK(h_empty, 1'b0)
         end
      join
      #1;
      `CHECK({ok1, ok2, g1, g2}, {2'h3, e1, e2})
      `CHECK(s_empty, 1'b0)
      for (i = 0; i < 400 && s_empty !== 1'b1; i++) tick(1);
      `CHECK(s_empty, 1'b1)
      $display("transmit test done");
   endtask
   task test_float;
      flt = 1'b1;
      tick(6);
      `CHECK(s_oe, 1'b0)
      flt = 1'b0;
      tick(6);
      `CHECK(s_oe, 1'b1)
      $display("float test done");
   endtask
   initial begin
      {rstn, mclr, latch, p_off, x_stop, wl_lo, wl_hi, ev_par, clr_n, flt} = 10'h000;
      load_n = 1'b1;
      clr_n = 1'b1;
      tx_data = 8'h00;
      repeat (6) @(posedge ref_clk);
      #5 rstn = 1'b1;
      tick(3);
      mclear_check(8'h00);
      test_rx_errors();
      test_rx_lengths();
      test_rx_framing();
      test_tx();
      test_float();
      test_done();
   end
endmodule // tb
